// *** src/acau_params.svh ***
// Constants for the accumulator carry and aux address datapath.
// Assumes inclusion by the datapath package users only.
`ifndef ACAU_PARAMS_SVH
`define ACAU_PARAMS_SVH
`define ACAU_ACC_MSB 31
`define ACAU_ACC_RESET 32'h0000_0000
`define ACAU_AUX_RESET 16'h0000
`define ACAU_SAT_POS 32'h7FFF_FFFF
`define ACAU_SAT_NEG 32'h8000_0000
`define ACAU_STATUS_CARRY_BIT 9
`define ACAU_STATUS_OVM_BIT 11
`endif

// *** src/acau_pkg.sv ***
// Types for the accumulator carry and aux address datapath.
// Assumes no surroundings beyond the including modules.
package acau_pkg;
  typedef enum logic [4:0] {
    ACAU_OP_NOP, ACAU_OP_ADD, ACAU_OP_SUB, ACAU_OP_ADD_HIGH_HALF_OP, ACAU_OP_SUB_HIGH_HALF_OP,
    ACAU_OP_ADD_WITH_CARRY_OP, ACAU_OP_SUB_WITH_BORROW_OP, ACAU_OP_ABS, ACAU_OP_NEG, ACAU_OP_SUBC,
    ACAU_OP_ROL, ACAU_OP_ROR, ACAU_OP_SFL, ACAU_OP_SFR, ACAU_OP_MSB_ALIGN_OP,
    ACAU_OP_LDST, ACAU_OP_CLRC, ACAU_OP_SETC, ACAU_OP_LOAD, ACAU_OP_MAC
  } acau_op_t;
  typedef enum logic [1:0] {ACAU_AM_NONE, ACAU_AM_INC, ACAU_AM_DEC, ACAU_AM_IDX} acau_am_t;
  typedef enum logic {ACAU_ST_IDLE, ACAU_ST_REPEAT} acau_state_t;
endpackage : acau_pkg

// *** src/acau_core.sv ***
// Accumulator, carry flag, normalize and aux address datapath.
// Assumes a sequencer presents one op per CORE_CLK cycle.
//
// Behaviour
// - Add carrying out of bit 31 sets carry.
// - Add with no carry out of bit 31 clears carry.
// - High-half add may only set carry.
// - Every accumulator arithmetic op updates carry.
// - Rotates and shifts load carry with the bit moved out.
// - Status load, clear-carry and set-carry write carry directly.
// - Saturation mode replaces overflow by limit; else wrapped result stored.
// - All arithmetic is two's-complement fixed point.
// - Normalize shifts one bit left when the accumulator is nonzero and its top two bits agree, and decrements selected aux register.
// - Aux unit increments, decrements or indexes in the same cycle.
// - Repeated MAC takes data and program operands in one cycle.
// - Each MAC cycle accumulates, multiplies, steps row, indexes column.
// - Subtract borrow out of bit 31 clears carry, else sets it.
// - High-half subtract may only clear carry.
`timescale 1ns/10ps
`include "acau_params.svh"
module acau_core
  import acau_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire acau_op_t OP,
  input wire logic [31:0] OPERAND,
  input wire logic [15:0] STATUS_IN,
  input wire acau_am_t AUX_MODE,
  input wire logic [2:0] AUX_SEL,
  input wire logic [15:0] AUX_LOAD_VALUE,
  input wire logic AUX_LOAD,
  input wire logic [15:0] DATA_BUS_IN,
  input wire logic [15:0] PROG_BUS_IN,
  input wire logic [15:0] PROG_START,
  input wire logic [7:0] REPEAT_COUNT,
  output logic [31:0] ACC,
  output logic CARRY,
  output logic OVERFLOW_SATURATE_MODE,
  output logic [31:0] PRODUCT,
  output logic [15:0] AUX_ADDR,
  output logic [15:0] PROG_ADDR,
  output logic MAC_BUSY
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  // Two-stage release of reset
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_n = rst_sync_ff;

  // ****************************************
  // State
  // ****************************************
  logic [31:0] acc_ff;
  logic carry_ff;
  logic ovm_ff;
  logic [31:0] prod_ff;
  logic [15:0] aux_ff [0:7];
  logic [15:0] idx_ff;
  logic [15:0] pc_ff;
  logic [7:0] rpt_ff;
  acau_state_t state_ff;

  // ****************************************
  // Arithmetic decode
  // ****************************************
  // Adder operand selection, carry-in and direction
  wire is_mac_step = (state_ff == ACAU_ST_REPEAT);
  wire [31:0] add_b = is_mac_step ? prod_ff : OPERAND;
  wire cin = (OP == ACAU_OP_ADD_WITH_CARRY_OP) ? carry_ff : ((OP == ACAU_OP_SUB_WITH_BORROW_OP) ? carry_ff : 1'b1);
  wire [32:0] sum_w = {1'b0, acc_ff} + {1'b0, add_b} + {32'h0000_0000, (OP == ACAU_OP_ADD_WITH_CARRY_OP) && carry_ff};
  wire [32:0] dif_w = {1'b0, acc_ff} + {1'b0, ~OPERAND} + {32'h0000_0000, cin};
  wire [32:0] neg_w = {1'b0, ~acc_ff} + 33'h0_0000_0001;
  wire add_ovf = (acc_ff[31] == add_b[31]) && (sum_w[31] != acc_ff[31]);
  wire sub_ovf = (acc_ff[31] != OPERAND[31]) && (dif_w[31] != acc_ff[31]);
  wire neg_ovf = (acc_ff == `ACAU_SAT_NEG);
  wire subc_pos = !dif_w[31];
  wire [31:0] subc_res = subc_pos ? {dif_w[30:0], 1'b1} : {acc_ff[30:0], 1'b0};

  // Saturation value from the sign of the true result
  function automatic logic [31:0] acau_sat(input logic [31:0] wrapped, input logic ovf, input logic overflow_saturate_mode);
    if (ovf && overflow_saturate_mode) begin
      acau_sat = wrapped[31] ? `ACAU_SAT_POS : `ACAU_SAT_NEG;
    end else begin
      acau_sat = wrapped;
    end
  endfunction : acau_sat

  // normalize when the accumulator is nonzero and the two top bits agree
  wire msb_align_op_go = (acc_ff != 32'h0000_0000) && (acc_ff[31] == acc_ff[30]);

  // Accumulator next value
  logic [31:0] nxt_acc;
  always_comb begin
    nxt_acc = acc_ff;
    case (OP)
      ACAU_OP_LOAD: nxt_acc = OPERAND;
      ACAU_OP_ADD, ACAU_OP_ADD_HIGH_HALF_OP, ACAU_OP_ADD_WITH_CARRY_OP: nxt_acc = acau_sat(sum_w[31:0], add_ovf, ovm_ff);
      ACAU_OP_SUB, ACAU_OP_SUB_HIGH_HALF_OP, ACAU_OP_SUB_WITH_BORROW_OP: nxt_acc = acau_sat(dif_w[31:0], sub_ovf, ovm_ff);
      ACAU_OP_SUBC: nxt_acc = subc_res;
      ACAU_OP_ABS: nxt_acc = acc_ff[31] ? acau_sat(neg_w[31:0], neg_ovf, ovm_ff) : acc_ff;
      ACAU_OP_NEG: nxt_acc = acau_sat(neg_w[31:0], neg_ovf, ovm_ff);
      ACAU_OP_ROL: nxt_acc = {acc_ff[30:0], carry_ff};
      ACAU_OP_ROR: nxt_acc = {carry_ff, acc_ff[31:1]};
      ACAU_OP_SFL: nxt_acc = {acc_ff[30:0], 1'b0};
      ACAU_OP_SFR: nxt_acc = {acc_ff[31], acc_ff[31:1]};
      ACAU_OP_MSB_ALIGN_OP: nxt_acc = msb_align_op_go ? {acc_ff[30:0], 1'b0} : acc_ff;
      default: nxt_acc = acc_ff;
    endcase
    if (is_mac_step) begin
      nxt_acc = acau_sat(sum_w[31:0], add_ovf, ovm_ff);
    end
  end

  // Carry next value
  logic nxt_carry;
  always_comb begin
    nxt_carry = carry_ff;
    case (OP)
      ACAU_OP_ADD, ACAU_OP_ADD_WITH_CARRY_OP: nxt_carry = sum_w[32];
      ACAU_OP_ADD_HIGH_HALF_OP: nxt_carry = carry_ff | sum_w[32];
      ACAU_OP_SUB, ACAU_OP_SUB_WITH_BORROW_OP, ACAU_OP_SUBC: nxt_carry = dif_w[32];
      ACAU_OP_SUB_HIGH_HALF_OP: nxt_carry = carry_ff & dif_w[32];
      ACAU_OP_NEG: nxt_carry = neg_w[32];
      ACAU_OP_ABS: nxt_carry = acc_ff[31] ? neg_w[32] : 1'b0;
      ACAU_OP_ROL, ACAU_OP_SFL: nxt_carry = acc_ff[31];
      ACAU_OP_ROR, ACAU_OP_SFR: nxt_carry = acc_ff[0];
      ACAU_OP_LDST: nxt_carry = STATUS_IN[`ACAU_STATUS_CARRY_BIT];
      ACAU_OP_CLRC: nxt_carry = 1'b0;
      ACAU_OP_SETC: nxt_carry = 1'b1;
      default: nxt_carry = carry_ff;
    endcase
    if (is_mac_step) begin
      nxt_carry = sum_w[32];
    end
  end

  // ****************************************
  // Aux address unit
  // ****************************************
  // step selected register in parallel
  function automatic logic [15:0] acau_step(input logic [15:0] a, input acau_am_t m, input logic [15:0] idx);
    case (m)
      ACAU_AM_INC: acau_step = a + 16'h0001;
      ACAU_AM_DEC: acau_step = a - 16'h0001;
      ACAU_AM_IDX: acau_step = a + idx;
      default: acau_step = a;
    endcase
  endfunction : acau_step

  wire [15:0] aux_cur = aux_ff[AUX_SEL];
  wire msb_align_op_adj = (OP == ACAU_OP_MSB_ALIGN_OP) && msb_align_op_go;
  wire mac_start = (OP == ACAU_OP_MAC) && !is_mac_step && (REPEAT_COUNT != 8'h00);
  wire [15:0] aux_msb_align_op = aux_cur - 16'h0001;
  wire [15:0] aux_next = msb_align_op_adj ? aux_msb_align_op : acau_step(aux_cur, is_mac_step ? ACAU_AM_IDX : AUX_MODE, idx_ff);
  wire [31:0] prod_next = 32'(signed'(DATA_BUS_IN) * signed'(PROG_BUS_IN));

  // ****************************************
  // Registers
  // ****************************************
  // Accumulator, carry and mode
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= `ACAU_ACC_RESET;
      carry_ff <= 1'b0;
      ovm_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      if (OP == ACAU_OP_LDST) begin
        ovm_ff <= STATUS_IN[`ACAU_STATUS_OVM_BIT];
      end
    end
  end

  // Aux registers, index register in slot zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_aux
      always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
          aux_ff[gi] <= `ACAU_AUX_RESET;
        end else if (AUX_LOAD && (AUX_SEL == gi)) begin
          aux_ff[gi] <= AUX_LOAD_VALUE;
        end else if (AUX_SEL == gi) begin
          aux_ff[gi] <= aux_next;
        end
      end
    end
  endgenerate
  assign idx_ff = aux_ff[0];

  // Repeated MAC sequencer
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ACAU_ST_IDLE;
      rpt_ff <= 8'h00;
      pc_ff <= 16'h0000;
      prod_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        ACAU_ST_IDLE: begin
          if (mac_start) begin
            state_ff <= ACAU_ST_REPEAT;
            rpt_ff <= REPEAT_COUNT - 8'h01;
            pc_ff <= PROG_START;
          end
        end
        ACAU_ST_REPEAT: begin
          prod_ff <= prod_next;
          pc_ff <= pc_ff + 16'h0001;
          if (rpt_ff == 8'h00) begin
            state_ff <= ACAU_ST_IDLE;
          end else begin
            rpt_ff <= rpt_ff - 8'h01;
          end
        end
        default: state_ff <= ACAU_ST_IDLE;
      endcase
    end
  end

  // Output flops
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ACC <= `ACAU_ACC_RESET;
      CARRY <= 1'b0;
      OVERFLOW_SATURATE_MODE <= 1'b0;
      PRODUCT <= 32'h0000_0000;
      AUX_ADDR <= 16'h0000;
      PROG_ADDR <= 16'h0000;
      MAC_BUSY <= 1'b0;
    end else begin
      ACC <= nxt_acc;
      CARRY <= nxt_carry;
      OVERFLOW_SATURATE_MODE <= (OP == ACAU_OP_LDST) ? STATUS_IN[`ACAU_STATUS_OVM_BIT] : ovm_ff;
      PRODUCT <= is_mac_step ? prod_next : prod_ff;
      AUX_ADDR <= aux_next;
      PROG_ADDR <= mac_start ? PROG_START : (is_mac_step ? pc_ff + 16'h0001 : pc_ff);
      MAC_BUSY <= mac_start || (is_mac_step && (rpt_ff != 8'h00));
    end
  end
endmodule : acau_core

// *** verification/acau_core_chk.sv ***
// Checker of carry and accumulator relations at the core ports.
// Assumes the bind below onto acau_core; ops after internal reset.
`timescale 1ns/10ps
module acau_chk
  import acau_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire acau_op_t OP,
  input wire logic [31:0] OPERAND,
  input wire logic [15:0] STATUS_IN,
  input wire logic [31:0] ACC,
  input wire logic CARRY,
  input wire logic OVERFLOW_SATURATE_MODE,
  input wire logic MAC_BUSY
);
  // Wide sum and difference, plain-mode gate
  wire logic [32:0] sum = {1'b0, ACC} + {1'b0, OPERAND};
  wire logic [32:0] dif = {1'b0, ACC} - {1'b0, OPERAND};
  wire logic live = !MAC_BUSY && !OVERFLOW_SATURATE_MODE;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_add_carry_out: assert property (live && OP == ACAU_OP_ADD |=> CARRY == $past(sum[32]))
    else $error("add carry wrong");
  a_add_wrap_value: assert property (live && OP == ACAU_OP_ADD |=> ACC == $past(sum[31:0]))
    else $error("add result wrong");
  a_sub_no_borrow: assert property (live && OP == ACAU_OP_SUB |=> CARRY == !$past(dif[32]))
    else $error("sub carry wrong");
  a_add_high_half_op_set_only: assert property (!MAC_BUSY && OP == ACAU_OP_ADD_HIGH_HALF_OP && CARRY |=> CARRY)
    else $error("high add cleared carry");
  a_sub_high_half_op_clear_only: assert property (!MAC_BUSY && OP == ACAU_OP_SUB_HIGH_HALF_OP && !CARRY |=> !CARRY)
    else $error("high sub set carry");
  a_carry_direct_write: assert property (!MAC_BUSY && (OP == ACAU_OP_CLRC || OP == ACAU_OP_SETC)
    |=> CARRY == $past(OP == ACAU_OP_SETC)) else $error("carry write wrong");
  a_status_load: assert property (!MAC_BUSY && OP == ACAU_OP_LDST |=> CARRY == $past(STATUS_IN[9])
    && OVERFLOW_SATURATE_MODE == $past(STATUS_IN[11])) else $error("status load wrong");
  a_rotate_left: assert property (!MAC_BUSY && OP == ACAU_OP_ROL |=> {CARRY, ACC} == {$past(ACC), $past(CARRY)})
    else $error("rotate wrong");
  a_add_with_carry_op_carry_in: assert property (live && OP == ACAU_OP_ADD_WITH_CARRY_OP |=> ACC == $past(sum[31:0]) + $past(CARRY))
    else $error("carry add wrong");
  a_carry_hold_idle: assert property (OP == ACAU_OP_NOP && !MAC_BUSY |=> $stable(CARRY))
    else $error("carry moved when idle");
  c_add_high_half_op_held: cover property (OP == ACAU_OP_ADD_HIGH_HALF_OP && CARRY);
  c_mac_run: cover property ($rose(MAC_BUSY));
  c_saturate: cover property (OVERFLOW_SATURATE_MODE && OP == ACAU_OP_ADD);
endmodule : acau_chk

bind acau_core acau_chk i_acau_chk (.CORE_CLK, .RESET_N, .OP, .OPERAND, .STATUS_IN, .ACC, .CARRY,
  .OVERFLOW_SATURATE_MODE, .MAC_BUSY);

// *** verification/accumulator_carry_and_aux_address_tb.sv ***
// Self-checking bench for the carry and aux address datapath.
// Assumes acau_core with its bound checker; inputs move on falling edges.
`timescale 1ns/10ps
`include "acau_params.svh"
module accumulator_carry_and_aux_address_tb
  import acau_pkg::*;
;
  logic CORE_CLK = 0, RESET_N = 0, AUX_LOAD = 0, CARRY, OVERFLOW_SATURATE_MODE, MAC_BUSY;
  logic m_c = 0, m_ovm = 0, m_ok = 1, m_cok = 1;
  acau_op_t OP = ACAU_OP_NOP;
  acau_op_t ar [8] = '{ACAU_OP_ADD, ACAU_OP_SUB, ACAU_OP_ADD_WITH_CARRY_OP, ACAU_OP_SUB_WITH_BORROW_OP,
    ACAU_OP_ROL, ACAU_OP_ROR, ACAU_OP_SFL, ACAU_OP_SFR};
  acau_am_t AUX_MODE = ACAU_AM_NONE;
  logic [2:0] AUX_SEL = '0;
  logic [7:0] REPEAT_COUNT = '0;
  logic [15:0] STATUS_IN = '0, AUX_LOAD_VALUE = '0, DATA_BUS_IN = '0, PROG_BUS_IN = '0, PROG_START = '0;
  logic [15:0] AUX_ADDR, PROG_ADDR, m_aux [8];
  logic [31:0] OPERAND = '0, ACC, PRODUCT, m_acc = '0;
  logic [51:0] q [$];
  logic [51:0] e;
  int fails = 0, checks_done = 0;
  acau_core i_acau_core (.CORE_CLK, .RESET_N, .OP, .OPERAND, .STATUS_IN, .AUX_MODE, .AUX_SEL,
    .AUX_LOAD_VALUE, .AUX_LOAD, .DATA_BUS_IN, .PROG_BUS_IN, .PROG_START, .REPEAT_COUNT, .ACC, .CARRY,
    .OVERFLOW_SATURATE_MODE, .PRODUCT, .AUX_ADDR, .PROG_ADDR, .MAC_BUSY);
  // ****************
  // Clock and watcher of noted results
  // ****************
  initial forever #5 CORE_CLK = ~CORE_CLK;
  always begin
    @(posedge CORE_CLK);
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      checks_done++;
      if (e[51] && ACC !== e[48:17]) bad("acc");
      if (e[50] && CARRY !== e[16]) bad("carry");
      if (e[49] && AUX_ADDR !== e[15:0]) bad("aux");
    end
  end
  task automatic bad(input string s);
    fails++;
    $display("[FAIL] %0t %s", $time, s);
  endtask : bad
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Drives one op and notes the expected outcome
  task automatic go(input acau_op_t o, input logic [31:0] x = 32'h0000_0000, input logic [2:0] sl = 3'h0,
      input acau_am_t am = ACAU_AM_NONE, input logic ld = 1'b0, input logic [15:0] v = 16'h0000);
    logic sb;
    logic ov;
    logic [32:0] s;
    @(negedge CORE_CLK);
    OP = o;
    OPERAND = x;
    STATUS_IN = x[15:0];
    AUX_SEL = sl;
    AUX_MODE = am;
    AUX_LOAD = ld;
    AUX_LOAD_VALUE = v;
    sb = o == ACAU_OP_SUB || o == ACAU_OP_SUB_WITH_BORROW_OP || o == ACAU_OP_SUB_HIGH_HALF_OP || o == ACAU_OP_SUBC;
    s = sb ? {1'b0, m_acc} - x - (o == ACAU_OP_SUB_WITH_BORROW_OP && !m_c) : {1'b0, m_acc} + x + (o == ACAU_OP_ADD_WITH_CARRY_OP && m_c);
    ov = ((m_acc[31] ^ x[31]) == sb) && (s[31] != m_acc[31]);
    case (o)
      ACAU_OP_ADD, ACAU_OP_ADD_WITH_CARRY_OP, ACAU_OP_SUB, ACAU_OP_SUB_WITH_BORROW_OP, ACAU_OP_ADD_HIGH_HALF_OP, ACAU_OP_SUB_HIGH_HALF_OP: begin
        m_c = o == ACAU_OP_ADD_HIGH_HALF_OP ? m_c | s[32] : o == ACAU_OP_SUB_HIGH_HALF_OP ? m_c & !s[32] : s[32] ^ sb;
        m_cok = !(ov && m_ovm);
        m_acc = (ov && m_ovm) ? (s[31] ? `ACAU_SAT_POS : `ACAU_SAT_NEG) : s[31:0];
      end
      ACAU_OP_SUBC: {m_c, m_acc} = {!s[32], s[31] ? {m_acc[30:0], 1'b0} : {s[30:0], 1'b1}};
      ACAU_OP_ABS, ACAU_OP_NEG: begin
        m_c = o == ACAU_OP_NEG && m_acc == 32'h0000_0000;
        if (o == ACAU_OP_NEG || m_acc[31])
          m_acc = (m_ovm && m_acc == `ACAU_SAT_NEG) ? `ACAU_SAT_POS : 32'h0000_0000 - m_acc;
      end
      ACAU_OP_MSB_ALIGN_OP:
        if (m_acc != 32'h0000_0000 && m_acc[31] == m_acc[30])
          {m_acc, m_aux[sl]} = {m_acc << 1, m_aux[sl] - 16'h0001};
      ACAU_OP_ROL: {m_c, m_acc} = {m_acc, m_c};
      ACAU_OP_ROR: {m_acc, m_c} = {m_c, m_acc};
      ACAU_OP_SFL: {m_c, m_acc} = {m_acc, 1'b0};
      ACAU_OP_SFR: {m_acc, m_c} = {m_acc[31], m_acc};
      ACAU_OP_LOAD: {m_ok, m_acc} = {1'b1, x};
      ACAU_OP_CLRC, ACAU_OP_SETC: {m_cok, m_c} = {1'b1, o == ACAU_OP_SETC};
      ACAU_OP_LDST: {m_cok, m_c, m_ovm} = {1'b1, x[9], x[11]};
      ACAU_OP_MAC: {m_ok, m_cok} = 2'b00;
      default: ;
    endcase
    if (ld) m_aux[sl] = v;
    else if (am != ACAU_AM_NONE) m_aux[sl] += am == ACAU_AM_INC ? 16'h0001 : am == ACAU_AM_DEC ? 16'hFFFF : m_aux[0];
    q.push_back({m_ok, m_cok, !ld && (am != ACAU_AM_NONE || o == ACAU_OP_MSB_ALIGN_OP), m_acc, m_c, m_aux[sl]});
  endtask : go
  // Main sequence
  initial begin
    void'($urandom(76736));
    m_aux = '{default: 16'h0000};
    repeat (16) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RESET_N = 1;
    repeat (3) @(posedge CORE_CLK);
    go(ACAU_OP_LOAD, 32'hFFFF_FFFF);
    go(ACAU_OP_ADD, 32'h0000_0001);
    go(ACAU_OP_ADD);
    repeat (24) go(ar[$urandom % 4], $urandom);
    go(ACAU_OP_LOAD);
    go(ACAU_OP_SUB, 32'h0000_0001);
    go(ACAU_OP_LOAD, 32'h8000_0001);
    for (int i = 4; i < 8; i++) go(ar[i]);
    go(ACAU_OP_ADD_HIGH_HALF_OP, 32'hFFFF_FFFF);
    go(ACAU_OP_LDST, 32'h0000_0200);
    go(ACAU_OP_ADD_HIGH_HALF_OP);
    go(ACAU_OP_NOP);
    go(ACAU_OP_CLRC);
    go(ACAU_OP_SUB_HIGH_HALF_OP, 32'h0000_0001);
    go(ACAU_OP_SETC);
    go(ACAU_OP_SUB_HIGH_HALF_OP, 32'h0001_0000);
    go(ACAU_OP_LDST, 32'h0000_0800);
    go(ACAU_OP_LOAD, 32'h7FFF_FFFF);
    go(ACAU_OP_ADD, 32'h0000_0001);
    go(ACAU_OP_LDST);
    go(ACAU_OP_LOAD, 32'h0000_0000, 3'h3, ACAU_AM_NONE, 1'b1, 16'h0100);
    go(ACAU_OP_ADD, 32'h0000_0005, 3'h3, ACAU_AM_INC);
    go(ACAU_OP_NOP, 32'h0000_0000, 3'h3, ACAU_AM_DEC);
    go(ACAU_OP_NOP, 32'h0000_0000, 3'h0, ACAU_AM_NONE, 1'b1, 16'h000A);
    go(ACAU_OP_SUB, 32'h0000_0002, 3'h3, ACAU_AM_IDX);
    repeat (3) go(ACAU_OP_MSB_ALIGN_OP, 32'h0000_0000, 3'h3);
    go(ACAU_OP_NEG);
    go(ACAU_OP_ABS);
    go(ACAU_OP_LOAD);
    go(ACAU_OP_NEG);
    go(ACAU_OP_LOAD, 32'h0000_0021);
    repeat (16) go(ACAU_OP_SUBC, 32'h0002_8000);
    go(ACAU_OP_LOAD);
    PROG_START = 16'($urandom);
    DATA_BUS_IN = $urandom & 16'h7FFF;
    PROG_BUS_IN = $urandom & 16'h7FFF;
    REPEAT_COUNT = 8'h04;
    go(ACAU_OP_MAC);
    go(ACAU_OP_NOP);
    for (int n = 0; MAC_BUSY !== 1'b0; n++) begin
      if (n == 50) begin
        bad("timeout");
        wrap_up();
      end
      go(ACAU_OP_NOP);
    end
    checks_done++;
    if (PRODUCT !== {16'h0000, DATA_BUS_IN} * {16'h0000, PROG_BUS_IN}) bad("product");
    checks_done++;
    if (ACC !== m_acc + 32'h0000_0003 * {16'h0000, DATA_BUS_IN} * {16'h0000, PROG_BUS_IN}) bad("mac sum");
    checks_done++;
    if (PROG_ADDR !== PROG_START + 16'h0004) bad("prog addr");
    go(ACAU_OP_CLRC);
    go(ACAU_OP_LOAD);
    go(ACAU_OP_NOP);
    @(posedge CORE_CLK);
    #2;
    wrap_up();
  end
endmodule : accumulator_carry_and_aux_address_tb
